/* cmpo_pkg.sv */
// constants, register map and state type of the comparator output logic
package cmpo_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CH_W   = 3;
  localparam int SYNC_STAGES = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B   = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_NEG_CH   = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_POS_CH   = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MIRROR   = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h18;

  // cmp_control_a fields
  localparam int CA_EN   = 7;
  localparam int CA_OUT  = 6;
  localparam int CA_POL  = 4;
  localparam int CA_HYS  = 1;
  localparam int CA_SYNC = 0;
  // cmp_control_b fields
  localparam int CB_GIE  = 7;
  localparam int CB_PIN_TRISTATE = 6;
  localparam int CB_RISE = 1;
  localparam int CB_FALL = 0;
  // status, mask and mirror share bit 0
  localparam int FLAG_BIT = 0;

  // channel select codes
  localparam logic [CH_W-1:0] CH_EXT0    = 3'h0;
  localparam logic [CH_W-1:0] CH_NEG_EXT3 = 3'h3;
  localparam logic [CH_W-1:0] CH_POS_DAC = 3'h4;
  localparam logic [CH_W-1:0] CH_FVR     = 3'h6;
  localparam logic [CH_W-1:0] CH_GND     = 3'h7;

  // reset values
  localparam logic [CH_W-1:0] CH_RESET   = 3'h0;
  localparam logic            PIN_TRISTATE_RESET = 1'b1;

  typedef struct packed {
    logic              enable;
    logic              polarity_invert;
    logic              hysteresis_enable;
    logic              sync_en;
    logic              rise_irq_enable;
    logic              fall_irq_enable;
    logic              global_irq_enable;
    logic              pin_tristate;
    logic              cmp_irq_enable;
    logic [CH_W-1:0]   pos_channel_select;
    logic [CH_W-1:0]   neg_channel_select;
    logic              out;
    logic              out_prev;
    logic              tclk_prev;
    logic              cap;
    logic              cmp_irq_flag;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              irq;
    logic              routed;
    logic              tmr_inc;
    logic              pin_oe;
    logic              pos_conn;
    logic              neg_conn;
  } cmpo_state_t;
endpackage

/* cmpo_sync.sv */
// multi-bit, multi-stage level synchroniser
module cmpo_sync #(
  parameter int W      = 2,
  parameter int STAGES = 2
) (
  input  wire logic         clock,   // system clock
  input  wire logic         resetn,  // async reset, active low
  input  wire logic [W-1:0] d,       // asynchronous levels
  output logic      [W-1:0] q        // synchronised levels
);
  logic [W-1:0] chain_q [STAGES];

  // each stage reads only the one before it, so no logic sees a metastable flop
  generate
    for (genvar i = 0; i < STAGES; i++)
    begin : g_stage
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          chain_q[i] <= '0;
        else if (i == 0)
          chain_q[i] <= d;
        else
          chain_q[i] <= chain_q[(i == 0) ? 0 : i-1];
      end
    end
  endgenerate

  assign q = chain_q[STAGES-1];
endmodule // cmpo_sync

/* cmpo_core.sv */
// comparator control, output, sync-capture and edge interrupt logic behind APB
// Overview of operation
// - uninverted result high when plus input exceeds minus
// - polarity bit one inverts the result
// - disabled: inputs disconnected, output low unless polarity bit set
// - sync mode captures output on timer falling edge
// - capture uses the prescaled timer clock
// - timer counts rising edge, capture on falling
// - internal output registered every instruction cycle
// - result readable alone and in shared mirror
// - enabled output edge sets the interrupt flag
// - polarity toggle while disabled still raises flag
// - positive select picks noninverting input source
// - hysteresis bit adds fixed input separation
// - output routable to pin when tristate cleared
// - positive codes: 0 pin, 4 dac, 6 ref, 7 ground
// - negative codes: 0-3 pins, 6 ref, 7 ground
// - sync off: timer and pin follow result directly
module cmpo_core
  import cmpo_pkg::*;
(
  input  wire logic              clock,              // 10 MHz instruction clock
  input  wire logic              resetn,             // async reset, active low
  input  wire logic              psel,               // apb select
  input  wire logic              penable,            // apb access phase
  input  wire logic              pwrite,             // apb direction, 1 = write
  input  wire logic [ADDR_W-1:0] paddr,              // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,             // apb write data
  output logic      [DATA_W-1:0] prdata,             // apb read data
  output logic                   pready,             // apb ready
  output logic                   pslverr,            // apb error on unmapped address
  input  wire logic              cmp_raw,            // analog core result, plus > minus
  input  wire logic              tmr_clk,            // prescaled sync_timer clock
  output logic                   ana_enable,         // analog core enable
  output logic      [CH_W-1:0]   pos_channel_select, // noninverting mux code
  output logic                   pos_conn,           // noninverting mux connected
  output logic      [CH_W-1:0]   neg_channel_select, // inverting mux code
  output logic                   neg_conn,           // inverting mux connected
  output logic                   hysteresis_enable,  // analog hysteresis on
  output logic                   tmr_cmp_out,        // comparator output to timer
  output logic                   tmr_inc,            // timer count pulse
  output logic                   pin_out,            // comparator output to pin
  output logic                   pin_oe,             // pin driver enable
  output logic                   irq                 // level interrupt
);
  cmpo_state_t s_q;
  cmpo_state_t s_d;
  logic        raw_s;
  logic        tclk_s;
  logic        setup;
  logic        done;
  logic        rise;
  logic        fall;
  logic        t_fall;
  logic        t_rise;

  // true when a select code reaches a real source
  function automatic logic chan_valid(input logic [CH_W-1:0] c, input logic is_pos);
    if (c == CH_FVR || c == CH_GND)
      return 1'b1;
    if (is_pos)
      return (c == CH_EXT0) || (c == CH_POS_DAC);
    return c <= CH_NEG_EXT3;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CTRL_A, ADDR_CTRL_B, ADDR_NEG_CH, ADDR_POS_CH,
      ADDR_MIRROR, ADDR_IRQ_STAT, ADDR_IRQ_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // read mux; unused bits read as zero
  function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a,
                                                input cmpo_state_t s);
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      ADDR_CTRL_A:
      begin
        w[CA_EN]   = s.enable;
        w[CA_OUT]  = s.out;
        w[CA_POL]  = s.polarity_invert;
        w[CA_HYS]  = s.hysteresis_enable;
        w[CA_SYNC] = s.sync_en;
      end
      ADDR_CTRL_B:
      begin
        w[CB_GIE]  = s.global_irq_enable;
        w[CB_PIN_TRISTATE] = s.pin_tristate;
        w[CB_RISE] = s.rise_irq_enable;
        w[CB_FALL] = s.fall_irq_enable;
      end
      ADDR_NEG_CH:   w[CH_W-1:0] = s.neg_channel_select;
      ADDR_POS_CH:   w[CH_W-1:0] = s.pos_channel_select;
      ADDR_MIRROR:   w[FLAG_BIT] = s.out;
      ADDR_IRQ_STAT: w[FLAG_BIT] = s.cmp_irq_flag;
      ADDR_IRQ_MASK: w[FLAG_BIT] = s.cmp_irq_enable;
      default:       w = '0;
    endcase
    return w;
  endfunction

  // analog result and timer clock are asynchronous to the instruction clock
  cmpo_sync #(
    .W      (2),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      ({tmr_clk, cmp_raw}),
    .q      ({tclk_s, raw_s})
  );

  // bus phase and edge decodes
  assign setup  = psel & ~penable;
  assign done   = psel & penable & s_q.pready;
  assign rise   = s_q.out & ~s_q.out_prev;
  assign fall   = ~s_q.out & s_q.out_prev;
  assign t_fall = s_q.tclk_prev & ~tclk_s;
  assign t_rise = ~s_q.tclk_prev & tclk_s;

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    // apb: no wait state, read data sampled in the setup cycle
    s_d.pready = setup;
    if (setup)
    begin
      s_d.prdata  = rd_word(paddr, s_q);
      s_d.pslverr = ~mapped(paddr);
    end
    if (done && pwrite && !s_q.pslverr)
    begin
      case (paddr)
        ADDR_CTRL_A:
        begin
          s_d.enable            = pwdata[CA_EN];
          s_d.polarity_invert   = pwdata[CA_POL];
          s_d.hysteresis_enable = pwdata[CA_HYS];
          s_d.sync_en           = pwdata[CA_SYNC];
        end
        ADDR_CTRL_B:
        begin
          s_d.global_irq_enable = pwdata[CB_GIE];
          s_d.pin_tristate      = pwdata[CB_PIN_TRISTATE];
          s_d.rise_irq_enable   = pwdata[CB_RISE];
          s_d.fall_irq_enable   = pwdata[CB_FALL];
        end
        ADDR_NEG_CH:   s_d.neg_channel_select = pwdata[CH_W-1:0];
        ADDR_POS_CH:   s_d.pos_channel_select = pwdata[CH_W-1:0];
        ADDR_IRQ_MASK: s_d.cmp_irq_enable     = pwdata[FLAG_BIT];
        default:       s_d.enable             = s_q.enable;
      endcase
    end
    // disabled core reads as 0 before polarity, so toggling polarity still flips it
    s_d.out      = (s_q.enable & raw_s) ^ s_q.polarity_invert;
    s_d.out_prev = s_q.out;
    // timer side: count on rise, capture on fall, so the two never race
    s_d.tclk_prev = tclk_s;
    s_d.tmr_inc   = t_rise;
    if (t_fall)
      s_d.cap = s_q.out;
    s_d.routed = s_q.sync_en ? s_q.cap : s_q.out;
    s_d.pin_oe = ~s_q.pin_tristate;
    // read clears only a flag that the read actually returned; a new edge wins
    if (done && !pwrite && paddr == ADDR_IRQ_STAT && s_q.prdata[FLAG_BIT])
      s_d.cmp_irq_flag = 1'b0;
    if ((rise && s_q.rise_irq_enable) || (fall && s_q.fall_irq_enable))
      s_d.cmp_irq_flag = 1'b1;
    s_d.irq = s_d.cmp_irq_flag & s_d.cmp_irq_enable & s_d.global_irq_enable;
    // every mux opens while the comparator is off
    s_d.pos_conn = s_q.enable & chan_valid(s_q.pos_channel_select, 1'b1);
    s_d.neg_conn = s_q.enable & chan_valid(s_q.neg_channel_select, 1'b0);
  end

  // state register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q                    <= '0;
      s_q.pin_tristate       <= PIN_TRISTATE_RESET;
      s_q.pos_channel_select <= CH_RESET;
      s_q.neg_channel_select <= CH_RESET;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from state flops
  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign ana_enable         = s_q.enable;
  assign pos_channel_select = s_q.pos_channel_select;
  assign pos_conn           = s_q.pos_conn;
  assign neg_channel_select = s_q.neg_channel_select;
  assign neg_conn           = s_q.neg_conn;
  assign hysteresis_enable  = s_q.hysteresis_enable;
  assign tmr_cmp_out        = s_q.routed;
  assign tmr_inc            = s_q.tmr_inc;
  assign pin_out            = s_q.routed;
  assign pin_oe             = s_q.pin_oe;
  assign irq                = s_q.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // enabled, uninverted: output follows synchronised result after one cycle
  track_raw_a: assert property (
    s_q.enable && !s_q.polarity_invert && $stable(s_q.enable)
      |=> s_q.out == $past(raw_s))
    else $error("output does not follow comparator result");

  // polarity flips a steady output
  pol_invert_a: assert property (
    s_q.enable && s_q.polarity_invert && $stable(s_q.polarity_invert)
      |=> s_q.out == !$past(raw_s))
    else $error("inverted output wrong");

  // disabled core: output low and muxes open
  disable_zero_a: assert property (
    !s_q.enable && !s_q.polarity_invert ##1 $stable(s_q.enable) && $stable(s_q.polarity_invert)
      |=> !s_q.out && !s_q.pos_conn && !s_q.neg_conn)
    else $error("disabled comparator not forced low");

  // capture only on a falling timer edge
  cap_hold_a: assert property (
    !t_fall |=> $stable(s_q.cap))
    else $error("capture changed without timer fall");

  cap_take_a: assert property (
    t_fall |=> s_q.cap == $past(s_q.out))
    else $error("capture missed timer fall");

  // count pulse never coincides with a capture edge
  count_edge_a: assert property (
    tmr_inc |-> $past(!t_fall) && $past(t_rise))
    else $error("timer count not on rising edge");

  // routed output matches mode a cycle later
  route_mode_a: assert property (
    $stable(s_q.sync_en) |=> tmr_cmp_out == ($past(s_q.sync_en) ? $past(s_q.cap)
                                                              : $past(s_q.out)))
    else $error("routed output wrong for mode");

  // enabled edge reaches flag in one cycle
  edge_flag_a: assert property (
    (rise && s_q.rise_irq_enable) || (fall && s_q.fall_irq_enable)
      |=> s_q.cmp_irq_flag)
    else $error("edge did not set flag");

  // polarity toggle while disabled raises the flag within three cycles
  pol_edge_irq_a: assert property (
    !s_q.enable && $stable(s_q.enable) && $changed(s_q.polarity_invert) && s_q.rise_irq_enable
      && s_q.fall_irq_enable ##1 !s_q.enable |-> ##[1:2] s_q.cmp_irq_flag)
    else $error("polarity toggle gave no interrupt");

  // negative code 3 connects, code 4 does not
  neg_map_a: assert property (
    s_q.enable && $stable(s_q.enable) && $stable(s_q.neg_channel_select)
      |=> neg_conn == ($past(s_q.neg_channel_select) <= CH_NEG_EXT3
                       || $past(s_q.neg_channel_select) >= CH_FVR))
    else $error("negative channel connect wrong");

  // mirror read agrees with the output status bit
  mirror_rd_a: assert property (
    setup && paddr == ADDR_MIRROR |=> prdata[FLAG_BIT] == $past(s_q.out))
    else $error("mirror read wrong");
endmodule // cmpo_core

/* cmpo_analog_model.sv */
// behavioural model of the analog comparator core and the prescaled timer clock
module cmpo_analog_model
  import cmpo_pkg::*;
(
  input  wire logic            ana_enable,   // analog core enable
  input  wire logic [CH_W-1:0] pos_sel,      // noninverting mux code
  input  wire logic            pos_conn,     // noninverting mux connected
  input  wire logic [CH_W-1:0] neg_sel,      // inverting mux code
  input  wire logic            neg_conn,     // inverting mux connected
  input  wire logic            plus_above,   // bench: plus voltage above minus
  input  wire logic            tmr_run,      // bench: let the timer clock run
  output logic                 cmp_raw,      // analog result
  output logic                 tmr_clk       // prescaled timer clock
);
  timeunit 1ns;
  timeprecision 1ns;
  int tmr_count;

  // a powered-down or unconnected core gives low, never a stale value;
  // both inputs on the same internal source can never show plus above minus
  assign cmp_raw = ana_enable & pos_conn & neg_conn & plus_above
                   & !((pos_sel == neg_sel) && (pos_sel >= CH_FVR));

  // timer clock stands low between bursts; period 700 ns, seven system clock periods
  initial
  begin
    tmr_clk = 1'b0;
    tmr_count = 0;
    forever
    begin
      wait (tmr_run === 1'b1);
      #350 tmr_clk = 1'b1;
      tmr_count++;
      #350 tmr_clk = 1'b0;
    end
  end
endmodule // cmpo_analog_model

/* tb_top.sv */
// self-checking testbench of the comparator output logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cmpo_pkg::*;
  logic              clock, resetn, psel, penable, pwrite, plus_above, tmr_run;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              pready, pslverr, cmp_raw, tmr_clk, ana_enable, pos_conn, neg_conn;
  logic              hysteresis_enable, tmr_cmp_out, tmr_inc, pin_out, pin_oe, irq, err;
  logic [CH_W-1:0]   pos_channel_select, neg_channel_select;
  int                error_cnt = 0, checks_done = 0, inc_cnt = 0;

  cmpo_core cmpo_core_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .tmr_clk(tmr_clk), .ana_enable(ana_enable),
    .pos_channel_select(pos_channel_select), .pos_conn(pos_conn),
    .neg_channel_select(neg_channel_select), .neg_conn(neg_conn),
    .hysteresis_enable(hysteresis_enable), .tmr_cmp_out(tmr_cmp_out), .tmr_inc(tmr_inc),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  cmpo_analog_model cmpo_analog_model_i (.ana_enable(ana_enable), .pos_sel(pos_channel_select),
    .pos_conn(pos_conn), .neg_sel(neg_channel_select), .neg_conn(neg_conn),
    .plus_above(plus_above), .tmr_run(tmr_run), .cmp_raw(cmp_raw), .tmr_clk(tmr_clk));

  // 100 ns clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // timer count pulses seen by the system clock
  always @(posedge clock)
    if (tmr_inc === 1'b1) inc_cnt++;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    checks_done++;
    if (exp !== got)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string w);
    apb(1'b0, a, 32'h0);
    chk(w, exp, rd);
  endtask

  // bounded wait for pin_out (sel 0) or irq (sel 1) to reach a level
  task automatic wait_out(input int sel, input logic v);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clock);
      if ((sel == 0 ? pin_out : irq) === v) return;
    end
    error_cnt++;
    $display("CHECK FAILED wait level %0d expected %0h seen other", sel, v);
    final_report();
  endtask

  task automatic t_reset();
    rdchk(ADDR_CTRL_A, 32'h0, "ctrl_a reset");
    rdchk(ADDR_CTRL_B, 32'h40, "ctrl_b reset");
    rdchk(ADDR_POS_CH, 32'h0, "pos reset");
    chk("pin_oe reset", 32'h0, {31'h0, pin_oe});
    apb(1'b0, 5'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_polarity();
    apb(1'b1, ADDR_CTRL_A, 32'h80);
    plus_above <= 1'b1;
    wait_out(0, 1'b1);
    rdchk(ADDR_MIRROR, 32'h1, "mirror");
    rdchk(ADDR_CTRL_A, 32'hC0, "ctrl_a out");
    apb(1'b1, ADDR_CTRL_A, 32'h90);
    wait_out(0, 1'b0);
    rdchk(ADDR_MIRROR, 32'h0, "mirror inv");
    chk("tmr out", 32'h0, {31'h0, tmr_cmp_out});
    $display("test polarity done");
  endtask

  // enables go in before any edge, so only edges after them may set the flag
  task automatic t_irq();
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, ADDR_CTRL_B, 32'hC3);
    plus_above <= 1'b0;
    wait_out(1, 1'b1);
    rdchk(ADDR_IRQ_STAT, 32'h1, "stat rise");
    wait_out(1, 1'b0);
    rdchk(ADDR_IRQ_STAT, 32'h0, "stat cleared");
    plus_above <= 1'b1;
    wait_out(1, 1'b1);
    rdchk(ADDR_IRQ_STAT, 32'h1, "stat fall");
    apb(1'b1, ADDR_CTRL_B, 32'hC2);
    apb(1'b1, ADDR_CTRL_A, 32'h80);
    wait_out(1, 1'b1);
    rdchk(ADDR_IRQ_STAT, 32'h1, "rise only");
    plus_above <= 1'b0;
    wait_out(0, 1'b0);
    repeat (2) @(posedge clock);
    rdchk(ADDR_IRQ_STAT, 32'h0, "fall ignored");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    plus_above <= 1'b1;
    wait_out(0, 1'b1);
    repeat (2) @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk(ADDR_IRQ_STAT, 32'h1, "stat masked");
    $display("test irq done");
  endtask

  task automatic t_disabled();
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, ADDR_CTRL_A, 32'h00);
    wait_out(0, 1'b0);
    chk("pos conn off", 32'h0, {31'h0, pos_conn});
    chk("neg conn off", 32'h0, {31'h0, neg_conn});
    rdchk(ADDR_IRQ_STAT, 32'h0, "stat idle");
    apb(1'b1, ADDR_CTRL_B, 32'hC3);
    apb(1'b1, ADDR_CTRL_A, 32'h10);
    wait_out(1, 1'b1);
    rdchk(ADDR_MIRROR, 32'h1, "mirror pol");
    $display("test disabled done");
  endtask

  task automatic t_channels();
    logic [CH_W-1:0] c;
    apb(1'b1, ADDR_CTRL_A, 32'h80);
    for (int i = 0; i < 8; i++)
    begin
      c = CH_W'(i);
      apb(1'b1, ADDR_POS_CH, {29'h0, c});
      apb(1'b1, ADDR_NEG_CH, {29'h0, c});
      rdchk(ADDR_POS_CH, {29'h0, c}, "pos code");
      chk("pos sel", {29'h0, c}, {29'h0, pos_channel_select});
      chk("neg sel", {29'h0, c}, {29'h0, neg_channel_select});
      chk("pos conn", {31'h0, c inside {0, 4, 6, 7}}, {31'h0, pos_conn});
      chk("neg conn", {31'h0, c != 4 && c != 5}, {31'h0, neg_conn});
    end
    apb(1'b1, ADDR_POS_CH, 32'h0);
    apb(1'b1, ADDR_NEG_CH, 32'h0);
    $display("test channels done");
  endtask

  task automatic t_pin_hys();
    apb(1'b1, ADDR_CTRL_A, 32'h82);
    apb(1'b1, ADDR_CTRL_B, 32'h00);
    rdchk(ADDR_CTRL_B, 32'h0, "ctrl_b clear");
    chk("hysteresis", 32'h1, {31'h0, hysteresis_enable});
    chk("pin_oe", 32'h1, {31'h0, pin_oe});
    chk("irq gie off", 32'h0, {31'h0, irq});
    $display("test pin done");
  endtask

  task automatic t_sync();
    int inc0;
    int tmr0;
    inc0 = inc_cnt;
    tmr0 = cmpo_analog_model_i.tmr_count;
    plus_above <= 1'b1;
    wait_out(0, 1'b1);
    // a timer burst with sync off leaves a known 1 in the capture flop
    tmr_run <= 1'b1;
    repeat (20) @(posedge clock);
    tmr_run <= 1'b0;
    repeat (10) @(posedge clock);
    apb(1'b1, ADDR_CTRL_A, 32'h81);
    plus_above <= 1'b0;
    repeat (12) @(posedge clock);
    chk("sync hold", 32'h1, {31'h0, pin_out});
    chk("hys cleared", 32'h0, {31'h0, hysteresis_enable});
    tmr_run <= 1'b1;
    wait_out(0, 1'b0);
    chk("tmr sync out", 32'h0, {31'h0, tmr_cmp_out});
    tmr_run <= 1'b0;
    repeat (10) @(posedge clock);
    chk("timer pulses", cmpo_analog_model_i.tmr_count - tmr0, inc_cnt - inc0);
    $display("test sync done");
  endtask

  initial
  begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; plus_above = 1'b0; tmr_run = 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_polarity();
    t_irq();
    t_disabled();
    t_channels();
    t_pin_hys();
    t_sync();
    final_report();
  end
endmodule // tb_top
